// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic i_clk, i_rst, i_infrared_strap_pin, i_reg_wr, i_reg_rd, i_efr_auto_flow;
	logic i_tx_disable, i_sw_flow_pending, i_sw_flow_halted, i_rx_char_done;
	logic i_rx_push, i_rx_push_err, i_rx_pop, i_rx_top_err, i_rx_top_pe, i_rx_top_fe;
	logic i_rx_frame_low, i_rx_line, i_tx_shift_busy, i_tx_serial, i_baud16_tick;
	logic i_rx_pin, i_cts_n, i_dsr_n, i_carrier_detect_n, i_ring_indicator_n;
	logic o_baud_clk_en, o_tx_pin, o_rx_serial, o_rts_n, o_dtr_n, o_xon_resume;
	logic o_tx_flow_stop, o_sci_load, o_rx_break_push, o_ls_irq, o_ms_irq, ring, carrier;
	logic [2:0] i_reg_addr;
	logic [3:0] lag;
	logic [6:0] i_rx_count, i_tx_count;
	logic [7:0] i_reg_wdata, i_interrupt_enable_reg, o_reg_rdata, o_sci_data;
	int failures, compares, n_sci, n_brk, n_baud, n_xon, s;
	ums_line_status dut_u (.*);
	ums_modem_peer peer_u (.i_clk(i_clk), .i_rts_n(o_rts_n), .i_dtr_n(o_dtr_n),
		.i_lag(lag), .i_ring(ring), .i_carrier(carrier), .o_cts_n(i_cts_n),
		.o_dsr_n(i_dsr_n), .o_ri_n(i_ring_indicator_n), .o_cd_n(i_carrier_detect_n));
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	// Pulse counters sample on the falling edge, clear of stimulus updates
	always @(negedge i_clk) begin
		n_sci += o_sci_load;
		n_brk += o_rx_break_push;
		n_baud += o_baud_clk_en;
		n_xon += o_xon_resume;
	end
	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask
	// Read data is launched by the edge that takes the strobe; it is looked at
	// on the next edge, before that edge updates it, so stimulus stays on edges
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		@(posedge i_clk);
		chk(o_reg_rdata, e);
	endtask
	task conclude;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Hang guard
	initial begin
		cyc(5000);
		failures++;
		conclude;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{i_rst, i_infrared_strap_pin, i_rx_line, i_rx_pin, i_tx_serial} = 5'h1F;
		{i_reg_wr, i_reg_rd, i_efr_auto_flow, i_tx_disable, i_sw_flow_pending} = 5'h00;
		{i_sw_flow_halted, i_rx_char_done, i_rx_push, i_rx_push_err, i_rx_pop} = 5'h00;
		{i_rx_top_err, i_rx_top_pe, i_rx_top_fe, i_rx_frame_low, i_tx_shift_busy} = 5'h00;
		{i_baud16_tick, ring, carrier} = 3'h0;
		{i_reg_addr, i_reg_wdata, i_rx_count, i_tx_count, lag} = 29'h0;
		i_interrupt_enable_reg = 8'h0C;
		cyc(8);
		i_rst <= 1'b0;
		cyc(2);
		// Strap high: infrared on, idle output low
		rd(3'h4, 8'h40);
		chk(8'({o_tx_pin, o_rts_n, o_dtr_n}), 8'h03);
		// A zero bit in infrared mode pulses the pin high
		i_tx_serial <= 1'b0;
		cyc(2);
		chk(8'(o_tx_pin), 8'h01);
		i_tx_serial <= 1'b1;
		rd(3'h5, 8'h60);
		rd(3'h6, 8'h00);
		wr(3'h4, 8'h80);
		cyc(8);
		s = n_baud;
		cyc(40);
		chk(8'(n_baud - s), 8'h0A);
		chk(8'(o_tx_pin), 8'h01);
		wr(3'h4, 8'h03);
		cyc(8);
		s = n_baud;
		cyc(40);
		chk(8'(n_baud - s), 8'h28);
		chk(8'({o_rts_n, o_dtr_n, o_ms_irq}), 8'h01);
		rd(3'h6, 8'h33);
		rd(3'h6, 8'h30);
		// Ring start sets no flag, ring end does
		cyc(1);
		ring <= 1'b1;
		cyc(4);
		rd(3'h6, 8'h70);
		cyc(1);
		ring <= 1'b0;
		carrier <= 1'b1;
		cyc(4);
		rd(3'h6, 8'hBC);
		// Automatic flow control against a slow peer
		cyc(1);
		i_efr_auto_flow <= 1'b1;
		lag <= 4'h5;
		wr(3'h4, 8'h01);
		cyc(12);
		chk(8'(o_tx_flow_stop), 8'h01);
		wr(3'h4, 8'h07);
		cyc(12);
		chk(8'(o_tx_flow_stop), 8'h00);
		i_tx_shift_busy <= 1'b1;
		wr(3'h4, 8'h06);
		cyc(12);
		chk(8'(o_tx_flow_stop), 8'h00);
		i_tx_shift_busy <= 1'b0;
		cyc(3);
		chk(8'(o_tx_flow_stop), 8'h01);
		i_efr_auto_flow <= 1'b0;
		lag <= 4'h0;
		// Local loopback
		wr(3'h4, 8'h10);
		wr(3'h4, 8'h1F);
		i_tx_serial <= 1'b0;
		cyc(3);
		chk(8'({o_rts_n, o_dtr_n, o_tx_pin, o_rx_serial}), 8'h0E);
		rd(3'h6, 8'hFB);
		wr(3'h4, 8'h16);
		rd(3'h6, 8'h5A);
		wr(3'h4, 8'h10);
		i_interrupt_enable_reg <= 8'h04;
		wr(3'h4, 8'h00);
		i_tx_serial <= 1'b1;
		cyc(4);
		chk(8'(o_ms_irq), 8'h00);
		// Immediate character waits for enable and flow characters
		i_interrupt_enable_reg <= 8'h0C;
		i_tx_disable <= 1'b1;
		i_sw_flow_pending <= 1'b1;
		s = n_sci;
		wr(3'h4, 8'h08);
		wr(3'h0, 8'hA5);
		cyc(20);
		i_tx_disable <= 1'b0;
		cyc(20);
		chk(8'(n_sci - s), 8'h00);
		i_sw_flow_pending <= 1'b0;
		cyc(6);
		chk(8'(n_sci - s), 8'h01);
		chk(o_sci_data, 8'hA5);
		rd(3'h4, 8'h00);
		// Goes after the character now shifting, ahead of the queue
		cyc(1);
		i_tx_count <= 7'h05;
		i_tx_shift_busy <= 1'b1;
		wr(3'h4, 8'h08);
		wr(3'h0, 8'h3C);
		cyc(10);
		chk(8'(n_sci - s), 8'h01);
		i_tx_shift_busy <= 1'b0;
		cyc(4);
		chk(8'(n_sci - s), 8'h02);
		chk(o_sci_data, 8'h3C);
		i_tx_count <= 7'h00;
		// Overrun with a full receive queue
		i_rx_count <= 7'h40;
		i_rx_char_done <= 1'b1;
		cyc(1);
		i_rx_char_done <= 1'b0;
		cyc(3);
		chk(8'(o_ls_irq), 8'h01);
		rd(3'h5, 8'h63);
		rd(3'h5, 8'h61);
		cyc(2);
		chk(8'(o_ls_irq), 8'h00);
		i_rx_count <= 7'h01;
		i_rx_push <= 1'b1;
		i_rx_push_err <= 1'b1;
		i_rx_top_pe <= 1'b1;
		cyc(1);
		i_rx_push <= 1'b0;
		rd(3'h5, 8'hE5);
		i_rx_top_pe <= 1'b0;
		i_rx_top_fe <= 1'b1;
		rd(3'h5, 8'hE9);
		i_rx_pop <= 1'b1;
		i_rx_top_err <= 1'b1;
		i_rx_top_fe <= 1'b0;
		i_rx_count <= 7'h00;
		cyc(1);
		i_rx_pop <= 1'b0;
		rd(3'h5, 8'h60);
		// Break held over two frames loads one entry
		s = n_brk;
		i_rx_line <= 1'b0;
		i_rx_frame_low <= 1'b1;
		cyc(1);
		i_rx_frame_low <= 1'b0;
		cyc(3);
		i_rx_frame_low <= 1'b1;
		cyc(1);
		i_rx_frame_low <= 1'b0;
		cyc(3);
		chk(8'(n_brk - s), 8'h01);
		rd(3'h5, 8'h70);
		i_rx_line <= 1'b1;
		i_tx_count <= 7'h03;
		cyc(2);
		rd(3'h5, 8'h00);
		i_tx_count <= 7'h00;
		i_tx_shift_busy <= 1'b1;
		cyc(2);
		rd(3'h5, 8'h20);
		i_tx_shift_busy <= 1'b0;
		// Any character resumes only with the bit set
		s = n_xon;
		i_sw_flow_halted <= 1'b1;
		i_rx_char_done <= 1'b1;
		cyc(1);
		i_rx_char_done <= 1'b0;
		wr(3'h4, 8'h20);
		cyc(3);
		i_rx_char_done <= 1'b1;
		cyc(1);
		i_rx_char_done <= 1'b0;
		cyc(3);
		chk(8'(n_xon - s), 8'h01);
		conclude;
	end
endmodule // tb

// ### dv/ums_line_status_asserts.sv
`timescale 1ns/1ps
module ums_line_status_asserts (
	input wire i_clk,
	input wire i_rst,
	input wire [2:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [7:0] i_reg_wdata,
	input wire [7:0] i_interrupt_enable_reg,
	input wire i_efr_auto_flow,
	input wire i_tx_disable,
	input wire i_sw_flow_pending,
	input wire i_sw_flow_halted,
	input wire i_rx_char_done,
	input wire [6:0] i_rx_count,
	input wire i_rx_line,
	input wire i_tx_shift_busy,
	input wire i_cts_n,
	input wire o_baud_clk_en,
	input wire o_rts_n,
	input wire o_dtr_n,
	input wire o_xon_resume,
	input wire o_tx_flow_stop,
	input wire o_sci_load,
	input wire o_rx_break_push,
	input wire o_ls_irq,
	input wire o_ms_irq
);
	// ------------------------------------------------------------
	// Shadow of the control register and settle counter
	// ------------------------------------------------------------
	reg [7:0] mc_q; // Last value written to modem control
	reg [2:0] age_q; // Cycles since that write, saturating
	reg brk_q; // Break pushed and line not yet back at mark
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mc_q <= 8'h00;
			age_q <= 3'h0;
			brk_q <= 1'b0;
		end else begin
			if (i_reg_wr && i_reg_addr == 3'h4)
				mc_q <= i_reg_wdata;
			age_q <= (i_reg_wr && i_reg_addr == 3'h4) ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
			brk_q <= o_rx_break_push | (brk_q & !i_rx_line);
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	property p_div1;
		age_q > 3'h2 && !mc_q[7] |-> o_baud_clk_en;
	endproperty
	a_div1: assert property (p_div1) else $error("baud enable gap");
	property p_div4;
		age_q == 3'h7 && mc_q[7] && o_baud_clk_en |=> !o_baud_clk_en [*3] ##1 o_baud_clk_en;
	endproperty
	a_div4: assert property (p_div4) else $error("baud divide wrong");
	property p_rts;
		age_q > 3'h2 && !mc_q[4] |-> o_rts_n == !mc_q[1];
	endproperty
	a_rts: assert property (p_rts) else $error("rts pin wrong");
	property p_dtr;
		age_q > 3'h2 && !mc_q[4] |-> o_dtr_n == !mc_q[0];
	endproperty
	a_dtr: assert property (p_dtr) else $error("dtr pin wrong");
	property p_xon;
		age_q > 3'h2 && mc_q[5] && i_rx_char_done && i_sw_flow_halted |=> o_xon_resume;
	endproperty
	a_xon: assert property (p_xon) else $error("no resume");
	property p_flow;
		(age_q > 3'h2 && mc_q[4:2] == 3'h0 && i_efr_auto_flow && !i_tx_shift_busy && i_cts_n) [*3]
			|-> o_tx_flow_stop;
	endproperty
	a_flow: assert property (p_flow) else $error("no flow stop");
	property p_flow_hold;
		$past(i_tx_shift_busy) |-> $stable(o_tx_flow_stop);
	endproperty
	a_flow_hold: assert property (p_flow_hold) else $error("stop mid char");
	property p_sci;
		o_sci_load |-> !$past(i_tx_disable) && !$past(i_sw_flow_pending);
	endproperty
	a_sci: assert property (p_sci) else $error("early load");
	property p_brk;
		brk_q |-> !o_rx_break_push;
	endproperty
	a_brk: assert property (p_brk) else $error("second break");
	property p_ovr;
		i_rx_char_done && i_rx_count == 7'h40 ##1 i_interrupt_enable_reg[2] |=> o_ls_irq;
	endproperty
	a_ovr: assert property (p_ovr) else $error("no line irq");
	property p_msk;
		!$past(i_interrupt_enable_reg[3]) |-> !o_ms_irq;
	endproperty
	a_msk: assert property (p_msk) else $error("masked irq");
endmodule // ums_line_status_asserts
bind ums_line_status ums_line_status_asserts chk_u (.*);

// ### dv/ums_modem_peer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Modem peer: answers the request lines after a set lag
// ------------------------------------------------------------
module ums_modem_peer (
	input wire i_clk, // Core clock
	input wire i_rts_n, // Request-to-send from the block
	input wire i_dtr_n, // Terminal-ready from the block
	input wire [3:0] i_lag, // Answer lag in cycles beyond one, 0 answers on the next cycle
	input wire i_ring, // Ringing in progress
	input wire i_carrier, // Carrier present
	output wire o_cts_n, // Clear-to-send back to the block
	output wire o_dsr_n, // Data-set-ready back to the block
	output wire o_ri_n, // Ring pin, low while ringing
	output wire o_cd_n // Carrier pin, low while present
);
	// Delay lines start deasserted so nothing is granted before asked
	reg [15:0] rts_q = 16'hFFFF;
	reg [15:0] dtr_q = 16'hFFFF;
	// A slow peer answers late, which is what flow control must survive
	always @(posedge i_clk) begin
		rts_q <= {rts_q[14:0], i_rts_n};
		dtr_q <= {dtr_q[14:0], i_dtr_n};
	end
	assign o_cts_n = rts_q[i_lag];
	assign o_dsr_n = dtr_q[i_lag];
	assign o_ri_n = !i_ring;
	assign o_cd_n = !i_carrier;
endmodule // ums_modem_peer

// ### verilog/ums_defs.vh
`ifndef UMS_DEFS_VH
`define UMS_DEFS_VH

// ----------------------------------------------------------------------
// Register port offsets (byte index on the 3-bit register address)
// ----------------------------------------------------------------------
`define UMS_ADDR_HOLDING 3'h0
`define UMS_ADDR_MODEM_CTRL 3'h4
`define UMS_ADDR_LINE_STATUS 3'h5
`define UMS_ADDR_MODEM_STATUS 3'h6

// ----------------------------------------------------------------------
// Modem control field positions
// ----------------------------------------------------------------------
`define UMS_MC_PRESCALE 7
`define UMS_MC_INFRARED 6
`define UMS_MC_XON_ANY 5
`define UMS_MC_LOOPBACK 4
`define UMS_MC_SEND_IMM 3
`define UMS_MC_FLOW_SEL 2
`define UMS_MC_RTS 1
`define UMS_MC_DTR 0

// ----------------------------------------------------------------------
// Line status field positions
// ----------------------------------------------------------------------
`define UMS_LS_FIFO_ERR 7
`define UMS_LS_TX_EMPTY 6
`define UMS_LS_THR_EMPTY 5
`define UMS_LS_BREAK 4
`define UMS_LS_FRAME 3
`define UMS_LS_PARITY 2
`define UMS_LS_OVERRUN 1
`define UMS_LS_DATA_RDY 0

// ----------------------------------------------------------------------
// Modem status field positions (upper levels, lower change flags)
// ----------------------------------------------------------------------
`define UMS_MS_CD 3
`define UMS_MS_RI 2
`define UMS_MS_DSR 1
`define UMS_MS_CTS 0

// ----------------------------------------------------------------------
// Interrupt enable field positions
// ----------------------------------------------------------------------
`define UMS_IE_LINE 2
`define UMS_IE_MODEM 3

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define UMS_MC_RESET 8'h00
`define UMS_BYTE_ZERO 8'h00
`define UMS_FIFO_DEPTH 7'h40
`define UMS_CNT_ZERO 7'h00
`define UMS_CNT_ONE 7'h01
`define UMS_PRESCALE_LAST 2'h3
`define UMS_IR_PULSE_TICKS 4'h3
`define UMS_IR_BIT_LAST 4'hF

`endif

// ### verilog/ums_line_status.v
`timescale 1ns/1ps
`include "ums_defs.vh"


module ums_line_status (
	input wire i_clk, // Core clock, 125 MHz
	input wire i_rst, // Asynchronous reset, active high
	input wire i_infrared_strap_pin, // Strap level caught after reset
	input wire [2:0] i_reg_addr, // Register index
	input wire i_reg_wr, // Register write strobe
	input wire i_reg_rd, // Register read strobe
	input wire [7:0] i_reg_wdata, // Write data
	input wire [7:0] i_interrupt_enable_reg, // Interrupt enables
	input wire i_efr_auto_flow, // Enhanced feature auto CTS/DSR enable
	input wire i_tx_disable, // Transmitter disable bit
	input wire i_sw_flow_pending, // Xon/Xoff character waiting to go
	input wire i_sw_flow_halted, // Transmit halted by received Xoff
	input wire i_rx_char_done, // Receive shifter finished a character
	input wire i_rx_push, // Character written into receive FIFO
	input wire i_rx_push_err, // Pushed character has parity/frame/break
	input wire i_rx_pop, // Top entry taken by host
	input wire i_rx_top_err, // Top entry has parity/frame/break
	input wire i_rx_top_pe, // Top entry parity error
	input wire i_rx_top_fe, // Top entry framing error
	input wire [6:0] i_rx_count, // Receive FIFO fill level
	input wire i_rx_frame_low, // Line low for a whole frame
	input wire i_rx_line, // Receive line level after decoding
	input wire [6:0] i_tx_count, // Transmit FIFO fill level
	input wire i_tx_shift_busy, // Transmit shifter holds a character
	input wire i_tx_serial, // Shifter serial output
	input wire i_baud16_tick, // 16x bit-rate tick
	input wire i_rx_pin, // External receive pin
	input wire i_cts_n, // Clear-to-send pin
	input wire i_dsr_n, // Data-set-ready pin
	input wire i_carrier_detect_n, // Carrier detect pin
	input wire i_ring_indicator_n, // Ring pin
	output reg [7:0] o_reg_rdata, // Read data, valid cycle after read
	output reg o_baud_clk_en, // Clock enable for the baud generator
	output reg o_tx_pin, // External transmit pin
	output reg o_rx_serial, // Serial data into the receive shifter
	output reg o_rts_n, // Request-to-send pin
	output reg o_dtr_n, // Terminal-ready pin
	output reg o_xon_resume, // Pulse: resume halted transmit
	output reg o_tx_flow_stop, // Level: hold transmitter at boundary
	output reg o_sci_load, // Pulse: shifter takes o_sci_data next
	output reg [7:0] o_sci_data, // Immediate character
	output reg o_rx_break_push, // Pulse: load the single break entry
	output reg o_ls_irq, // Line status interrupt
	output reg o_ms_irq // Modem status interrupt
);

	// ------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------
	wire wr_mc = i_reg_wr & (i_reg_addr == `UMS_ADDR_MODEM_CTRL);
	wire wr_hold = i_reg_wr & (i_reg_addr == `UMS_ADDR_HOLDING);
	wire rd_ls = i_reg_rd & (i_reg_addr == `UMS_ADDR_LINE_STATUS);
	wire rd_ms = i_reg_rd & (i_reg_addr == `UMS_ADDR_MODEM_STATUS);
	wire any_acc = i_reg_wr | i_reg_rd; // Any register access

	reg [7:0] mc_q; // Modem control register
	reg strap_pend_q; // Strap not yet captured since reset
	reg sci_armed_q; // Bit set, waiting for the very next access
	reg sci_pend_q; // Byte captured, waiting for a boundary
	wire loop = mc_q[`UMS_MC_LOOPBACK];
	wire irda = mc_q[`UMS_MC_INFRARED];
	reg [3:0] ms_lvl_n; // Active-low view of {cd, ri, dsr, cts}
	reg thr_empty_q; // Holding register or FIFO empty

	// ------------------------------------------------------------------
	// Modem control register and send-immediate sequencing
	// ------------------------------------------------------------------
	// Strap is caught by a clocked edge after release, never by reset
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mc_q <= `UMS_MC_RESET;
			strap_pend_q <= 1'b1;
			sci_armed_q <= 1'b0;
			sci_pend_q <= 1'b0;
			o_sci_data <= `UMS_BYTE_ZERO;
			o_sci_load <= 1'b0;
		end else begin
			o_sci_load <= 1'b0;
			strap_pend_q <= 1'b0;
			if (strap_pend_q) begin
				mc_q[`UMS_MC_INFRARED] <= i_infrared_strap_pin;
			end
			if (wr_mc) begin
				// Software may override the strap value later
				mc_q <= i_reg_wdata;
				sci_armed_q <= i_reg_wdata[`UMS_MC_SEND_IMM] &
					~i_reg_wdata[`UMS_MC_LOOPBACK];
			end else if (sci_armed_q & any_acc) begin
				// Only a holding write as next access takes the byte
				sci_armed_q <= 1'b0;
				mc_q[`UMS_MC_SEND_IMM] <= 1'b0;
				if (wr_hold) begin
					o_sci_data <= i_reg_wdata;
					sci_pend_q <= 1'b1;
				end
			end
			// Release once shifter is idle, transmitter on, no Xon/Xoff due
			if (sci_pend_q & ~i_tx_shift_busy & ~i_tx_disable & ~i_sw_flow_pending) begin
				o_sci_load <= 1'b1;
				sci_pend_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Clock prescaler
	// ------------------------------------------------------------------
	reg [1:0] pre_q; // Divide-by-four phase
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pre_q <= 2'h0;
			o_baud_clk_en <= 1'b0;
		end else begin
			pre_q <= pre_q + 2'h1;
			if (mc_q[`UMS_MC_PRESCALE]) begin
				o_baud_clk_en <= (pre_q == `UMS_PRESCALE_LAST);
			end else begin
				o_baud_clk_en <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Infrared encoder and decoder, loopback routing
	// ------------------------------------------------------------------
	reg [3:0] ir_tx_ph_q; // Position in the transmit bit
	reg [3:0] ir_rx_hold_q; // Ticks left of a decoded zero
	reg tx_prev_q; // Shifter output last cycle, for bit alignment
	wire ir_rx_pulse = i_rx_pin; // Encoded pulse is active high

	// Encoder pulses high for three sixteenths of each zero bit.
	// Decoder stretches each pulse to one bit time.
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ir_tx_ph_q <= 4'h0;
			ir_rx_hold_q <= 4'h0;
			tx_prev_q <= 1'b1;
		end else begin
			tx_prev_q <= i_tx_serial;
			if (tx_prev_q != i_tx_serial) begin
				ir_tx_ph_q <= 4'h0;
			end else if (i_baud16_tick) begin
				ir_tx_ph_q <= ir_tx_ph_q + 4'h1;
			end
			if (ir_rx_pulse) begin
				ir_rx_hold_q <= `UMS_IR_BIT_LAST;
			end else if (i_baud16_tick && ir_rx_hold_q != 4'h0) begin
				ir_rx_hold_q <= ir_rx_hold_q - 4'h1;
			end
		end
	end

	// Loopback feeds the shifter back and parks the pin at idle
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_tx_pin <= 1'b1;
			o_rx_serial <= 1'b1;
		end else begin
			if (loop) begin
				o_tx_pin <= ~irda;
				o_rx_serial <= i_tx_serial;
			end else if (irda) begin
				// Idle mark never pulses, so the pin rests low
				o_tx_pin <= ~i_tx_serial & (ir_tx_ph_q < `UMS_IR_PULSE_TICKS);
				o_rx_serial <= ~(ir_rx_pulse | (ir_rx_hold_q != 4'h0));
			end else begin
				o_tx_pin <= i_tx_serial;
				o_rx_serial <= i_rx_pin;
			end
		end
	end

	// ------------------------------------------------------------------
	// Modem outputs and flow control
	// ------------------------------------------------------------------
	// In loopback the pins stay inactive so the peer sees nothing
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rts_n <= 1'b1;
			o_dtr_n <= 1'b1;
			o_tx_flow_stop <= 1'b0;
			o_xon_resume <= 1'b0;
		end else begin
			o_rts_n <= loop | ~mc_q[`UMS_MC_RTS];
			o_dtr_n <= loop | ~mc_q[`UMS_MC_DTR];
			// Sampled only between characters, so a stop lets the current one finish
			if (~i_tx_shift_busy) begin
				o_tx_flow_stop <= i_efr_auto_flow & (mc_q[`UMS_MC_FLOW_SEL] ?
					ms_lvl_n[`UMS_MS_DSR] : ms_lvl_n[`UMS_MS_CTS]);
			end
			o_xon_resume <= mc_q[`UMS_MC_XON_ANY] & i_rx_char_done & i_sw_flow_halted;
		end
	end

	// ------------------------------------------------------------------
	// Modem status levels
	// ------------------------------------------------------------------
	always @* begin
		if (loop) begin
			ms_lvl_n[`UMS_MS_CD] = ~mc_q[`UMS_MC_SEND_IMM];
			ms_lvl_n[`UMS_MS_RI] = ~mc_q[`UMS_MC_FLOW_SEL];
			ms_lvl_n[`UMS_MS_DSR] = ~mc_q[`UMS_MC_DTR];
			ms_lvl_n[`UMS_MS_CTS] = ~mc_q[`UMS_MC_RTS];
		end else begin
			ms_lvl_n[`UMS_MS_CD] = i_carrier_detect_n;
			ms_lvl_n[`UMS_MS_RI] = i_ring_indicator_n;
			ms_lvl_n[`UMS_MS_DSR] = i_dsr_n;
			ms_lvl_n[`UMS_MS_CTS] = i_cts_n;
		end
	end
	wire [3:0] ms_lvl = ~ms_lvl_n; // Upper status bits, complement of pins
	wire [3:0] ms_delta; // Sticky change flags

	ums_modem_delta u_delta (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_status(ms_lvl),
		.i_clear(rd_ms),
		.o_delta(ms_delta)
	);

	// ------------------------------------------------------------------
	// Receive error bookkeeping
	// ------------------------------------------------------------------
	reg [6:0] err_cnt_q; // Erroneous entries still in the FIFO
	reg overrun_q; // Sticky overrun
	reg break_q; // Break held until mark
	reg brk_loaded_q; // Break entry already loaded this break
	wire err_in = i_rx_push & i_rx_push_err;
	wire err_out = i_rx_pop & i_rx_top_err & (err_cnt_q != `UMS_CNT_ZERO);

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			err_cnt_q <= `UMS_CNT_ZERO;
			overrun_q <= 1'b0;
			break_q <= 1'b0;
			brk_loaded_q <= 1'b0;
			o_rx_break_push <= 1'b0;
		end else begin
			// Count follows pushes and pops of flagged entries
			if (err_in & ~err_out) begin
				err_cnt_q <= err_cnt_q + `UMS_CNT_ONE;
			end else if (err_out & ~err_in) begin
				err_cnt_q <= err_cnt_q - `UMS_CNT_ONE;
			end
			// Full FIFO: shifter content dropped, flag set; set beats read clear
			if (i_rx_char_done & (i_rx_count == `UMS_FIFO_DEPTH)) begin
				overrun_q <= 1'b1;
			end else if (rd_ls) begin
				overrun_q <= 1'b0;
			end
			// One break entry per break; rearm on return to mark
			o_rx_break_push <= i_rx_frame_low & ~brk_loaded_q;
			if (i_rx_frame_low) begin
				break_q <= 1'b1;
				brk_loaded_q <= 1'b1;
			end else if (i_rx_line) begin
				break_q <= 1'b0;
				brk_loaded_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Line status word
	// ------------------------------------------------------------------
	wire rx_has = (i_rx_count != `UMS_CNT_ZERO);
	wire [7:0] ls_word;
	assign ls_word[`UMS_LS_FIFO_ERR] = (err_cnt_q != `UMS_CNT_ZERO);
	assign ls_word[`UMS_LS_TX_EMPTY] = thr_empty_q & ~i_tx_shift_busy;
	assign ls_word[`UMS_LS_THR_EMPTY] = thr_empty_q;
	assign ls_word[`UMS_LS_BREAK] = break_q;
	assign ls_word[`UMS_LS_FRAME] = rx_has & i_rx_top_fe;
	assign ls_word[`UMS_LS_PARITY] = rx_has & i_rx_top_pe;
	assign ls_word[`UMS_LS_OVERRUN] = overrun_q;
	assign ls_word[`UMS_LS_DATA_RDY] = rx_has;

	// Holding empty: a fresh write clears at once, else tracks the FIFO level
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			thr_empty_q <= 1'b1;
		end else if (wr_hold) begin
			thr_empty_q <= 1'b0;
		end else begin
			thr_empty_q <= (i_tx_count == `UMS_CNT_ZERO);
		end
	end

	// ------------------------------------------------------------------
	// Read data and interrupts
	// ------------------------------------------------------------------
	wire ls_err = ls_word[`UMS_LS_FIFO_ERR] | overrun_q | break_q;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= `UMS_BYTE_ZERO;
			o_ls_irq <= 1'b0;
			o_ms_irq <= 1'b0;
		end else begin
			case (i_reg_addr)
				`UMS_ADDR_MODEM_CTRL: begin
					o_reg_rdata <= mc_q;
				end
				`UMS_ADDR_LINE_STATUS: begin
					o_reg_rdata <= ls_word;
				end
				`UMS_ADDR_MODEM_STATUS: begin
					o_reg_rdata <= {ms_lvl, ms_delta};
				end
				default: begin
					o_reg_rdata <= `UMS_BYTE_ZERO;
				end
			endcase
			o_ls_irq <= i_interrupt_enable_reg[`UMS_IE_LINE] & ls_err;
			// Flags already cleared by a read drop the request next cycle
			o_ms_irq <= i_interrupt_enable_reg[`UMS_IE_MODEM] & (|ms_delta);
		end
	end

endmodule // ums_line_status

// ### verilog/ums_modem_delta.v
`timescale 1ns/1ps
`include "ums_defs.vh"

module ums_modem_delta (
	input wire i_clk, // Core clock
	input wire i_rst, // Asynchronous reset, active high
	input wire [3:0] i_status, // Active-high modem levels {cd, ri, dsr, cts}
	input wire i_clear, // Status register read strobe
	output wire [3:0] o_delta // Sticky change flags
);

	// ------------------------------------------------------------------
	// Per-input change detection
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_bit
			reg prev_q; // Level seen on the last cycle
			reg delta_q; // Sticky flag of this input
			wire chg; // Qualifying change on this input
			// Ring flags only the end of ringing: pin low-to-high, level 1-to-0
			if (g == `UMS_MS_RI) begin : g_ring
				assign chg = prev_q & ~i_status[g];
			end else begin : g_any
				assign chg = prev_q ^ i_status[g];
			end

			// Set wins over the read clear so no edge is lost
			always @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					prev_q <= 1'b0;
					delta_q <= 1'b0;
				end else begin
					prev_q <= i_status[g];
					if (chg) begin
						delta_q <= 1'b1;
					end else if (i_clear) begin
						delta_q <= 1'b0;
					end
				end
			end

			// Each bit owns its flag, so no vector has two driving processes
			assign o_delta[g] = delta_q;
		end
	endgenerate

endmodule // ums_modem_delta
